// ### rtl/hmic_defs.svh
/*
  Constants of the monitor configuration and interrupt block: host port
  offsets, internal register indices, field positions, reset values and
  the reset pulse timing.
  Assumes a 50 MHz core clock; included by bare name from the reset pulse and top design files.
*/
`ifndef HMIC_DEFS_SVH
`define HMIC_DEFS_SVH

// Host port offsets (low three address bits)
`define HMIC_PORT_POST_A 3'h0
`define HMIC_PORT_POST_B 3'h4
`define HMIC_PORT_ADDR 3'h5
`define HMIC_PORT_DATA 3'h6

// Internal register indices reached through the data port
`define HMIC_IDX_POST_LAST 7'h1F
`define HMIC_IDX_CFG 7'h40
`define HMIC_IDX_STAT_LO 7'h41
`define HMIC_IDX_STAT_HI 7'h42
`define HMIC_IDX_MASK_LO 7'h43
`define HMIC_IDX_MASK_HI 7'h44
`define HMIC_IDX_VAL_HI_FIRST 7'h60
`define HMIC_IDX_VAL_LAST 7'h7F

// Configuration field positions
`define HMIC_CFG_START 0
`define HMIC_CFG_MGMT_EN 1
`define HMIC_CFG_HOST_EN 2
`define HMIC_CFG_HOLD 3
`define HMIC_CFG_RESET 4
`define HMIC_CFG_NMI_SEL 5
`define HMIC_CFG_BYPASS 6
`define HMIC_CFG_INIT 7
`define HMIC_MASKHI_RST_EN 7

// Reset values
`define HMIC_CFG_POR 8'h08
`define HMIC_ZERO8 8'h00
`define HMIC_PTR_POR 7'h00

// Boot code buffer geometry
`define HMIC_POST_DEPTH 32
`define HMIC_POST_LAST_IDX 6'h1F
`define HMIC_POST_FULL_IDX 6'h20

// Reset pulse timing: printed time, clock rate and derived cycle count
`define HMIC_RST_PULSE_MS 20
`define HMIC_CLK_KHZ 50000
`define HMIC_RST_PULSE_CYC (`HMIC_RST_PULSE_MS * `HMIC_CLK_KHZ)
`define HMIC_RST_CNT_W 20

`endif

// ### rtl/hmic_pkg.sv
/*
  Types of the monitor configuration and interrupt block: host request
  carrier, monitor event carrier and the reset pulse state encoding.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package hmic_pkg;

  // One host bus cycle, sampled on the core clock
  typedef struct packed {
    logic wr;            // One-cycle write strobe
    logic rd;            // One-cycle read strobe
    logic [2:0] addr;    // Port offset
    logic [7:0] wdata;   // Write data
  } hmic_host_req_t;

  // Limit and fan comparison results from the measuring logic
  typedef struct packed {
    logic [4:0] limitLo; // Voltage channels 0..3 and internal temperature
    logic [1:0] fanLo;   // Fan tachometers 1 and 2
    logic [2:0] limitHi; // Voltage channel 4 and the two negative channels
    logic fanHi;         // Fan tachometer 3
  } hmic_mon_evt_t;

  // Reset pulse sequencer, Gray coded along idle, pulse, done
  typedef enum logic [1:0] {
    HMIC_PULSE_IDLE = 2'b00,
    HMIC_PULSE_LOW = 2'b01,
    HMIC_PULSE_DONE = 2'b11
  } hmic_pulse_state_t;

endpackage : hmic_pkg

`default_nettype wire

// ### rtl/hmic_reset_pulse.sv
/*
  Reset pulse generator: drives an active-low pulse for a fixed number of
  core clock cycles after a start strobe and flags its end for one cycle.
  Assumes start is a one-cycle strobe and is not raised while busy.
*/
`include "hmic_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module hmic_reset_pulse #(
  parameter int unsigned PULSE_CYCLES = `HMIC_RST_PULSE_CYC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic start,
  output var logic resetPulse_b,
  output var logic done
);

  hmic_pkg::hmic_pulse_state_t state_reg; // Sequencer state
  hmic_pkg::hmic_pulse_state_t state_next;
  logic [`HMIC_RST_CNT_W-1:0] cnt_reg;    // Cycles spent low
  logic [`HMIC_RST_CNT_W-1:0] cnt_next;
  logic pulse_next;
  wire lastCycle = (cnt_reg == `HMIC_RST_CNT_W'(PULSE_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Next state: the low phase lasts exactly PULSE_CYCLES clocks
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    pulse_next = resetPulse_b;
    case (state_reg)
      hmic_pkg::HMIC_PULSE_IDLE: begin
        if (start) begin // Begin pulse
          state_next = hmic_pkg::HMIC_PULSE_LOW;
          cnt_next = '0;
          pulse_next = 1'b0;
        end
      end
      hmic_pkg::HMIC_PULSE_LOW: begin
        if (lastCycle) begin // Release pin
          state_next = hmic_pkg::HMIC_PULSE_DONE;
          pulse_next = 1'b1;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      hmic_pkg::HMIC_PULSE_DONE: begin
        state_next = hmic_pkg::HMIC_PULSE_IDLE; // One cycle to self-clear
      end
      default: begin
        state_next = hmic_pkg::HMIC_PULSE_IDLE;
        pulse_next = 1'b1;
      end
    endcase
  end

  // State registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= hmic_pkg::HMIC_PULSE_IDLE;
      cnt_reg <= '0;
      resetPulse_b <= 1'b1;
      done <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      resetPulse_b <= pulse_next;
      done <= (state_next == hmic_pkg::HMIC_PULSE_DONE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin goes low on the cycle after the start strobe
  property p_pulseStarts;
    @(posedge core_clk) disable iff (!rst_b)
    (start && state_reg == hmic_pkg::HMIC_PULSE_IDLE) |=> !resetPulse_b;
  endproperty
  a_pulseStarts: assert property (p_pulseStarts) else $error("pulse did not start");

  // Pin may only rise after the full count
  property p_pulseLength;
    @(posedge core_clk) disable iff (!rst_b)
    (!resetPulse_b && !lastCycle) |=> !resetPulse_b;
  endproperty
  a_pulseLength: assert property (p_pulseLength) else $error("pulse ended early");

endmodule : hmic_reset_pulse
`default_nettype wire

// ### rtl/hmic_top.sv
/*
  Configuration and interrupt logic of a hardware monitor: address and data
  ports, boot code buffer, configuration, two sticky status registers, two
  management mask registers, and the interrupt, reset and bypass pins.
  Assumes host strobes are synchronous one-cycle pulses and that event
  inputs come from logic already clocked by core_clk.
*/
`include "hmic_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module hmic_top #(
  parameter int unsigned RST_PULSE_CYCLES = `HMIC_RST_PULSE_CYC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire hmic_pkg::hmic_host_req_t hostReq,
  output var logic [7:0] hostRdata,
  input wire hmic_pkg::hmic_mon_evt_t monEvt,
  input wire logic boardOvertempIn_b,
  input wire logic chassisIntrusionIn,
  input wire logic chainedIrqIn_b,
  output var logic mgmtIrqOut_b,
  output var logic hostNmiOut_b,
  output var logic hostIrqOut_b,
  output var logic sysReset_b,
  output var logic bypassOut,
  output var logic bypassOe
);

  ////////////////////////////////////////////////////////////////////////////
  // Pointer step after a data port access: the buffer stops at its top,
  // paired registers advance to their partner, the value area climbs
  function automatic logic [6:0] hmicNextPtr(input logic [6:0] p);
    if (p < `HMIC_IDX_POST_LAST)
      return 7'(p + 7'h01);
    else if (p == `HMIC_IDX_STAT_LO || p == `HMIC_IDX_MASK_LO)
      return 7'(p + 7'h01);
    else if (p >= `HMIC_IDX_VAL_HI_FIRST && p < `HMIC_IDX_VAL_LAST)
      return 7'(p + 7'h01);
    else
      return p;
  endfunction : hmicNextPtr

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [6:0] ptr_reg;            // Address pointer
  logic busy_reg;                 // Set by pointer write, cleared by data access
  logic [7:0] cfg_reg;            // Configuration
  logic [7:0] statLo_reg;         // First status register
  logic [6:0] statHi_reg;         // Second status register, bit 7 reserved
  logic [7:0] maskLo_reg;         // First management mask
  logic [7:0] maskHi_reg;         // Second management mask, bit 7 reset enable
  logic [5:0] postIdx_reg;        // Write index of buffer port, saturates at 32
  logic [7:0] postMem [0:`HMIC_POST_DEPTH-1]; // Boot code buffer

  logic [6:0] ptr_next;
  logic [7:0] cfg_next;
  logic [7:0] statLo_next;
  logic [6:0] statHi_next;
  logic [7:0] rdata_next;
  logic pulseDone;
  logic pulseLow_b;

  ////////////////////////////////////////////////////////////////////////////
  // Port decode
  wire selAddrPort = (hostReq.addr == `HMIC_PORT_ADDR);
  wire selDataPort = (hostReq.addr == `HMIC_PORT_DATA);
  wire selPostPort = (hostReq.addr == `HMIC_PORT_POST_A) || (hostReq.addr == `HMIC_PORT_POST_B);
  wire addrWr = hostReq.wr && selAddrPort;
  wire dataWr = hostReq.wr && selDataPort;
  wire dataRd = hostReq.rd && selDataPort;
  wire dataAcc = dataWr || dataRd;
  wire postWr = hostReq.wr && selPostPort;

  // Register decode behind the data port
  wire ptrInPost = (ptr_reg <= `HMIC_IDX_POST_LAST);
  wire ptrCfg = (ptr_reg == `HMIC_IDX_CFG);
  wire ptrStatLo = (ptr_reg == `HMIC_IDX_STAT_LO);
  wire ptrStatHi = (ptr_reg == `HMIC_IDX_STAT_HI);
  wire ptrMaskLo = (ptr_reg == `HMIC_IDX_MASK_LO);
  wire ptrMaskHi = (ptr_reg == `HMIC_IDX_MASK_HI);

  // Soft initialisation and reset pulse requests from a config write
  wire cfgWr = dataWr && ptrCfg;
  wire softInit = cfgWr && hostReq.wdata[`HMIC_CFG_INIT];
  wire rstEnable = maskHi_reg[`HMIC_MASKHI_RST_EN];
  wire pulseBusy = cfg_reg[`HMIC_CFG_RESET];
  wire pulseStart = cfgWr && !softInit && hostReq.wdata[`HMIC_CFG_RESET]
                    && rstEnable && !pulseBusy;

  ////////////////////////////////////////////////////////////////////////////
  // Monitoring runs only with start set and hold clear; in standby or hold
  // the comparison results are ignored, but pin-driven events still latch
  wire monitoring = cfg_reg[`HMIC_CFG_START] && !cfg_reg[`HMIC_CFG_HOLD];

  // Buffer overflow: the 32nd location is being written through the port
  wire postOverflow = postWr && (postIdx_reg == `HMIC_POST_LAST_IDX);

  // Event sets for both status registers
  wire [7:0] setLo = {monEvt.fanLo & {2{monitoring}},
                      !boardOvertempIn_b,
                      monEvt.limitLo & {5{monitoring}}};
  wire [6:0] setHi = {!chainedIrqIn_b,
                      postOverflow,
                      chassisIntrusionIn,
                      monEvt.fanHi && monitoring,
                      monEvt.limitHi & {3{monitoring}}};

  // Read of a status register clears it; soft init clears both
  wire clrLo = (dataRd && ptrStatLo) || softInit;
  wire clrHi = (dataRd && ptrStatHi) || softInit;

  // Set wins over clear so an event in the read cycle survives
  assign statLo_next = (statLo_reg & ~{8{clrLo}}) | setLo;
  assign statHi_next = (statHi_reg & ~{7{clrHi}}) | setHi;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration next value: init wins and reads back as zero in bit 7;
  // the reset bit stands while the pulse runs and drops when it ends
  wire resetBitNext = pulseStart || (pulseBusy && !pulseDone);
  always_comb begin
    cfg_next = cfg_reg;
    if (softInit) begin
      cfg_next = `HMIC_CFG_POR;
    end else if (cfgWr) begin
      cfg_next = {1'b0, hostReq.wdata[6:5], 1'b0, hostReq.wdata[3:0]};
    end
    if (!softInit) begin
      cfg_next[`HMIC_CFG_RESET] = resetBitNext;
    end
  end

  // Pointer: pointer port write loads it, data access steps it
  always_comb begin
    ptr_next = ptr_reg;
    if (softInit) begin
      ptr_next = `HMIC_PTR_POR;
    end else if (addrWr) begin
      ptr_next = hostReq.wdata[6:0];
    end else if (dataAcc) begin
      ptr_next = hmicNextPtr(ptr_reg);
    end
  end

  // Read data: pointer port shows busy and pointer, data port the target
  always_comb begin
    rdata_next = `HMIC_ZERO8;
    if (selAddrPort) begin
      rdata_next = {busy_reg, ptr_reg};
    end else if (selDataPort) begin
      if (ptrInPost) begin
        rdata_next = postMem[ptr_reg[4:0]];
      end else if (ptrCfg) begin
        rdata_next = cfg_reg;
      end else if (ptrStatLo) begin
        rdata_next = statLo_reg;
      end else if (ptrStatHi) begin
        rdata_next = {1'b0, statHi_reg};
      end else if (ptrMaskLo) begin
        rdata_next = maskLo_reg;
      end else if (ptrMaskHi) begin
        rdata_next = maskHi_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt conditions; the host pin has no mask here and sees any flag
  wire anyMgmt = |(statLo_reg & ~maskLo_reg) || |(statHi_reg & ~maskHi_reg[6:0]);
  wire anyHost = |statLo_reg || |statHi_reg;
  wire hold = cfg_reg[`HMIC_CFG_HOLD];
  // The start bit is deliberately absent, so standby keeps a pending pin
  wire mgmtAct = anyMgmt && cfg_reg[`HMIC_CFG_MGMT_EN] && !hold;
  wire hostAct = anyHost && cfg_reg[`HMIC_CFG_HOST_EN] && !hold;
  wire nmiSel = cfg_reg[`HMIC_CFG_NMI_SEL];

  ////////////////////////////////////////////////////////////////////////////
  // Control and status registers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_reg <= `HMIC_CFG_POR;
      ptr_reg <= `HMIC_PTR_POR;
      statLo_reg <= `HMIC_ZERO8;
      statHi_reg <= 7'h00;
    end else begin
      cfg_reg <= cfg_next;
      ptr_reg <= ptr_next;
      statLo_reg <= statLo_next;
      statHi_reg <= statHi_next;
    end
  end

  // Mask registers and busy flag
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      maskLo_reg <= `HMIC_ZERO8;
      maskHi_reg <= `HMIC_ZERO8;
      busy_reg <= 1'b0;
    end else if (softInit) begin
      maskLo_reg <= `HMIC_ZERO8;
      maskHi_reg <= `HMIC_ZERO8;
      busy_reg <= 1'b0;
    end else begin
      if (dataWr && ptrMaskLo) maskLo_reg <= hostReq.wdata;
      if (dataWr && ptrMaskHi) maskHi_reg <= hostReq.wdata;
      busy_reg <= addrWr || (busy_reg && !dataAcc);
    end
  end

  // Buffer write index; port writes beyond the 32nd location are dropped
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      postIdx_reg <= 6'h00;
    end else if (softInit) begin
      postIdx_reg <= 6'h00;
    end else if (postWr && postIdx_reg != `HMIC_POST_FULL_IDX) begin
      postIdx_reg <= postIdx_reg + 6'h01;
    end
  end

  // Buffer storage; not cleared by reset, contents are don't-care at power-on
  always_ff @(posedge core_clk) begin
    if (postWr && postIdx_reg != `HMIC_POST_FULL_IDX) begin
      postMem[postIdx_reg[4:0]] <= hostReq.wdata;
    end else if (dataWr && ptrInPost) begin
      postMem[ptr_reg[4:0]] <= hostReq.wdata;
    end
  end

  // Output pins except the constant bypassOut, all registered
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hostRdata <= `HMIC_ZERO8;
      mgmtIrqOut_b <= 1'b1;
      hostNmiOut_b <= 1'b1;
      hostIrqOut_b <= 1'b1;
      bypassOe <= 1'b0;
      sysReset_b <= 1'b1;
    end else begin
      if (hostReq.rd) hostRdata <= rdata_next;
      mgmtIrqOut_b <= !mgmtAct;
      hostNmiOut_b <= !(hostAct && nmiSel);
      hostIrqOut_b <= !(hostAct && !nmiSel);
      bypassOe <= cfg_next[`HMIC_CFG_BYPASS];
      sysReset_b <= pulseLow_b;
    end
  end

  // Open-drain bypass: only ever drives low, enable decides
  assign bypassOut = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset pulse timer
  hmic_reset_pulse #(
    .PULSE_CYCLES(RST_PULSE_CYCLES)
  ) hmic_reset_pulse_i (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .start(pulseStart),
    .resetPulse_b(pulseLow_b),
    .done(pulseDone)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_holdQuiet;
    @(posedge core_clk) disable iff (!rst_b)
    hold |=> (mgmtIrqOut_b && hostNmiOut_b && hostIrqOut_b);
  endproperty
  a_holdQuiet: assert property (p_holdQuiet) else $error("pin active during hold");

  property p_standbyNoLimit;
    @(posedge core_clk) disable iff (!rst_b)
    (!monitoring && !statLo_reg[0]) |=> !statLo_reg[0];
  endproperty
  a_standbyNoLimit: assert property (p_standbyNoLimit) else $error("limit latched idle");

  property p_mgmtDisabled;
    @(posedge core_clk) disable iff (!rst_b)
    !cfg_reg[`HMIC_CFG_MGMT_EN] |=> mgmtIrqOut_b;
  endproperty
  a_mgmtDisabled: assert property (p_mgmtDisabled) else $error("mgmt pin while disabled");

  property p_hostDisabled;
    @(posedge core_clk) disable iff (!rst_b)
    !cfg_reg[`HMIC_CFG_HOST_EN] |=> (hostNmiOut_b && hostIrqOut_b);
  endproperty
  a_hostDisabled: assert property (p_hostDisabled) else $error("host pin while disabled");

  property p_hostSelect;
    @(posedge core_clk) disable iff (!rst_b)
    (hostAct && nmiSel) |=> (!hostNmiOut_b && hostIrqOut_b);
  endproperty
  a_hostSelect: assert property (p_hostSelect) else $error("wrong host pin selected");

  property p_softInit;
    @(posedge core_clk) disable iff (!rst_b)
    softInit |=> (cfg_reg == `HMIC_CFG_POR && maskLo_reg == `HMIC_ZERO8);
  endproperty
  a_softInit: assert property (p_softInit) else $error("init left state");

  property p_mgmtAssert;
    @(posedge core_clk) disable iff (!rst_b)
    (|(statLo_reg & ~maskLo_reg) && cfg_reg[`HMIC_CFG_MGMT_EN] && !hold) |=> !mgmtIrqOut_b;
  endproperty
  a_mgmtAssert: assert property (p_mgmtAssert) else $error("mgmt pin not asserted");

  property p_maskBlocks;
    @(posedge core_clk) disable iff (!rst_b)
    (maskLo_reg == 8'hFF && (statHi_reg & ~maskHi_reg[6:0]) == 7'h00) |=> mgmtIrqOut_b;
  endproperty
  a_maskBlocks: assert property (p_maskBlocks) else $error("masked flag raised pin");

  property p_sticky;
    @(posedge core_clk) disable iff (!rst_b)
    (statLo_reg[0] && !clrLo) |=> statLo_reg[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status lost unread");

  property p_overflow;
    @(posedge core_clk) disable iff (!rst_b)
    postOverflow |=> statHi_reg[5];
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged");

  property p_resetBitClears;
    @(posedge core_clk) disable iff (!rst_b)
    pulseDone |=> !cfg_reg[`HMIC_CFG_RESET];
  endproperty
  a_resetBitClears: assert property (p_resetBitClears) else $error("reset bit stuck");

endmodule : hmic_top
`default_nettype wire

// ### tb/hmic_host_model.sv
/*
  Host processor model: byte accesses to the address and data ports.
  Assumes one-cycle strobes taken on the core clock rising edge.
*/
`timescale 1ns/10ps
`default_nettype none

module hmic_host_model (
  input wire logic core_clk,
  output var hmic_pkg::hmic_host_req_t hostReq,
  input wire logic [7:0] hostRdata
);
  // Bus idle until the first task call
  initial hostReq = '0;

  // One write strobe, then an idle cycle
  task automatic writePort(input logic [2:0] addr, input logic [7:0] data);
    @(posedge core_clk);
    hostReq <= {1'b1, 1'b0, addr, data};
    @(posedge core_clk);
    hostReq <= '0;
  endtask : writePort

  // Read data is registered on the taking edge
  task automatic readPort(input logic [2:0] addr, output logic [7:0] data);
    @(posedge core_clk);
    hostReq <= {1'b0, 1'b1, addr, 8'h00};
    @(posedge core_clk);
    hostReq <= '0;
    #1;
    data = hostRdata;
  endtask : readPort

  // Pointer first, then the data port
  task automatic writeReg(input logic [6:0] idx, input logic [7:0] data);
    writePort(3'h5, {1'b0, idx});
    writePort(3'h6, data);
  endtask : writeReg

  task automatic readReg(input logic [6:0] idx, output logic [7:0] data);
    writePort(3'h5, {1'b0, idx});
    readPort(3'h6, data);
  endtask : readReg
endmodule : hmic_host_model

`default_nettype wire

// ### tb/hmic_top_tb.sv
/*
  Self-checking bench of the monitor configuration and interrupt block.
  Assumes the host model file is compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none

module hmic_top_tb;
  localparam int unsigned PulseCyc = 8; // Short reset pulse for simulation
  logic core_clk, rst_b, boardOvertempIn_b, chassisIntrusionIn, chainedIrqIn_b;
  logic mgmtIrqOut_b, hostNmiOut_b, hostIrqOut_b, sysReset_b, bypassOut, bypassOe;
  logic [7:0] hostRdata;
  hmic_pkg::hmic_host_req_t hostReq;
  hmic_pkg::hmic_mon_evt_t monEvt;
  int fails, cmpCount;

  hmic_top #(.RST_PULSE_CYCLES(PulseCyc)) hmic_top_i (.core_clk(core_clk), .rst_b(rst_b),
    .hostReq(hostReq), .hostRdata(hostRdata), .monEvt(monEvt),
    .boardOvertempIn_b(boardOvertempIn_b), .chassisIntrusionIn(chassisIntrusionIn),
    .chainedIrqIn_b(chainedIrqIn_b), .mgmtIrqOut_b(mgmtIrqOut_b),
    .hostNmiOut_b(hostNmiOut_b), .hostIrqOut_b(hostIrqOut_b), .sysReset_b(sysReset_b),
    .bypassOut(bypassOut), .bypassOe(bypassOe));

  hmic_host_model hmic_host_model_i (.core_clk(core_clk), .hostReq(hostReq),
    .hostRdata(hostRdata));

  ////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // Single comparison on byte values
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmpCount++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s exp %h got %h", name, exp, got);
    end
  endtask : check

  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    hmic_host_model_i.writeReg(idx, d);
  endtask : wr

  task automatic rdChk(input logic [6:0] idx, input logic [7:0] exp, input string name);
    logic [7:0] d;
    hmic_host_model_i.readReg(idx, d);
    check(name, exp, d);
  endtask : rdChk

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle

  // One-cycle event on every source; idle levels restored after
  task automatic evt(input logic [10:0] mon, input logic bt, input logic ch, input logic cn);
    @(posedge core_clk);
    monEvt <= mon;
    boardOvertempIn_b <= bt;
    chassisIntrusionIn <= ch;
    chainedIrqIn_b <= cn;
    @(posedge core_clk);
    monEvt <= '0;
    boardOvertempIn_b <= 1'b1;
    chassisIntrusionIn <= 1'b0;
    chainedIrqIn_b <= 1'b1;
  endtask : evt

  ////////////////////////////////////////////////////////////////////////
  // Watchdog: the sequence needs about 300 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    end_of_test();
  end

  // Main sequence
  initial begin
    logic [7:0] d;
    int k, n;
    monEvt = '0;
    boardOvertempIn_b = 1'b1;
    chassisIntrusionIn = 1'b0;
    chainedIrqIn_b = 1'b1;
    rst_b = 1'b0;
    fails = 0;
    cmpCount = 0;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    rdChk(7'h40, 8'h08, "cfg por");
    hmic_host_model_i.readPort(3'h5, d);
    check("pointer", 8'h40, d);
    rdChk(7'h43, 8'h00, "mask por");
    wr(7'h41, 8'hFF);
    rdChk(7'h41, 8'h00, "status write");
    // Sticky flags survive a cleared start bit
    wr(7'h40, 8'h03);
    evt(11'h7F0, 1'b1, 1'b0, 1'b1);
    settle(2);
    check("mgmt set", 8'h00, {7'h00, mgmtIrqOut_b});
    wr(7'h40, 8'h02);
    settle(2);
    check("mgmt stop", 8'h00, {7'h00, mgmtIrqOut_b});
    rdChk(7'h41, 8'hDF, "status low");
    settle(2);
    check("mgmt clear", 8'h01, {7'h00, mgmtIrqOut_b});
    rdChk(7'h41, 8'h00, "reread");
    wr(7'h40, 8'h03);
    evt(11'h00F, 1'b1, 1'b1, 1'b0);
    rdChk(7'h42, 8'h5F, "status high");
    evt(11'h000, 1'b0, 1'b0, 1'b1);
    rdChk(7'h41, 8'h20, "board temp");
    // Masked flags are recorded but stay off the pin
    wr(7'h43, 8'hFF);
    evt(11'h7C0, 1'b1, 1'b0, 1'b1);
    settle(2);
    check("mgmt masked", 8'h01, {7'h00, mgmtIrqOut_b});
    rdChk(7'h41, 8'h1F, "masked status");
    wr(7'h43, 8'h00);
    // Hold: pins quiet, limits ignored, pin sources kept
    wr(7'h40, 8'h0B);
    evt(11'h080, 1'b1, 1'b0, 1'b0);
    settle(2);
    check("mgmt hold", 8'h01, {7'h00, mgmtIrqOut_b});
    wr(7'h40, 8'h03);
    settle(2);
    check("mgmt resume", 8'h00, {7'h00, mgmtIrqOut_b});
    rdChk(7'h41, 8'h00, "limit in hold");
    rdChk(7'h42, 8'h40, "kept in hold");
    // Host pin enable and routing
    wr(7'h40, 8'h05);
    evt(11'h080, 1'b1, 1'b0, 1'b1);
    settle(2);
    check("mgmt off", 8'h01, {7'h00, mgmtIrqOut_b});
    check("irq on", 8'h00, {7'h00, hostIrqOut_b});
    check("nmi idle", 8'h01, {7'h00, hostNmiOut_b});
    wr(7'h40, 8'h25);
    settle(2);
    check("nmi on", 8'h00, {7'h00, hostNmiOut_b});
    check("irq idle", 8'h01, {7'h00, hostIrqOut_b});
    wr(7'h40, 8'h21);
    settle(2);
    check("nmi off", 8'h01, {7'h00, hostNmiOut_b});
    rdChk(7'h41, 8'h02, "host source");
    wr(7'h40, 8'h02);
    evt(11'h080, 1'b1, 1'b0, 1'b1);
    rdChk(7'h41, 8'h00, "standby");
    wr(7'h40, 8'h40);
    settle(1);
    check("bypass", 8'h01, {7'h00, bypassOe & ~bypassOut});
    // Reset pulse refused, then enabled and timed
    wr(7'h40, 8'h10);
    settle(PulseCyc + 2);
    check("no pulse", 8'h01, {7'h00, sysReset_b});
    wr(7'h44, 8'h80);
    wr(7'h40, 8'h10);
    k = 0;
    while (sysReset_b !== 1'b0 && k < 20) begin
      settle(1);
      k++;
    end
    n = 0;
    while (sysReset_b === 1'b0 && n < 100) begin
      settle(1);
      n++;
    end
    check("pulse len", 8'(PulseCyc), n[7:0]);
    rdChk(7'h40, 8'h00, "self clear");
    // Boot buffer overflow on the 32nd push
    for (k = 0; k < 31; k++) hmic_host_model_i.writePort(3'h0, k[7:0]);
    rdChk(7'h42, 8'h00, "31 pushes");
    hmic_host_model_i.writePort(3'h4, 8'h1F);
    rdChk(7'h42, 8'h20, "overflow");
    rdChk(7'h00, 8'h00, "slot zero");
    // Soft init restores defaults
    wr(7'h43, 8'h55);
    wr(7'h40, 8'h47);
    wr(7'h40, 8'h80);
    rdChk(7'h40, 8'h08, "init cfg");
    rdChk(7'h43, 8'h00, "init mask");
    end_of_test();
  end
endmodule : hmic_top_tb

`default_nettype wire
